// *** pkg/pic_defs.svh ***
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH

// Register byte addresses
`define PIC_OFF_PRIO_TIMERS   32'hFFFF_0020
`define PIC_OFF_PRIO_PERIPH   32'hFFFF_0024
`define PIC_OFF_PRIO_SLAVES   32'hFFFF_0028
`define PIC_OFF_TRIG_CFG      32'hFFFF_0034
`define PIC_OFF_NEST_STAT     32'hFFFF_013C
`define PIC_OFF_NORM_VEC      32'hFFFF_0200
`define PIC_OFF_FAST_VEC      32'hFFFF_0204
`define PIC_OFF_VEC_BASE      32'hFFFF_0208
`define PIC_OFF_NORM_EN       32'hFFFF_020C
`define PIC_OFF_FAST_EN       32'hFFFF_0210
`define PIC_OFF_NEST_CTL      32'hFFFF_0214
`define PIC_OFF_EDGE_CLR      32'hFFFF_0218
`define PIC_OFF_EVT_STAT      32'hFFFF_021C
`define PIC_OFF_EVT_MASK      32'hFFFF_0220
`define PIC_OFF_RAW_REQ       32'hFFFF_0224

// Reset values
`define PIC_RST_WORD          32'h0000_0000
`define PIC_RST_BYTE          8'h00

// Writable bits of the priority and trigger registers
`define PIC_MASK_PRIO_TIMERS  32'h0777_7070
`define PIC_MASK_PRIO_PERIPH  32'h7777_7700
`define PIC_MASK_PRIO_SLAVES  32'h0000_7777
`define PIC_MASK_TRIG_CFG     32'h0000_00FF

// Priority field positions (low bit of each 3-bit field)
`define PIC_FLD_SW            4
`define PIC_FLD_TIMER0        12
`define PIC_FLD_TIMER1        16
`define PIC_FLD_TIMER2        20
`define PIC_FLD_TIMER3        24
`define PIC_FLD_CONV          8
`define PIC_FLD_ASYNC         12
`define PIC_FLD_SPI_M         16
`define PIC_FLD_PIN0          20
`define PIC_FLD_PIN1          24
`define PIC_FLD_TWI_M         28
`define PIC_FLD_TWI_S         0
`define PIC_FLD_SPI_S         4
`define PIC_FLD_PIN2          8
`define PIC_FLD_PIN3          12

// Source numbers shown in the vector
`define PIC_SRC_SW            1
`define PIC_SRC_CONV          5
`define PIC_SRC_ASYNC         6
`define PIC_SRC_TIMER0        7
`define PIC_SRC_TIMER1        8
`define PIC_SRC_TIMER2        9
`define PIC_SRC_TIMER3        10
`define PIC_SRC_SPI_M         11
`define PIC_SRC_PIN0          12
`define PIC_SRC_PIN1          13
`define PIC_SRC_TWI_M         14
`define PIC_SRC_PIN2          15
`define PIC_SRC_PIN3          16
`define PIC_SRC_SPI_S         17
`define PIC_SRC_TWI_S         18

// Vector layout and nesting control
`define PIC_VEC_BASE_LSB      7
`define PIC_VEC_IDX_LSB       2
`define PIC_NEST_EN_BIT       1
`define PIC_NO_BLOCK          4'h8

`endif

// *** pkg/pic_pkg.sv ***
package pic_pkg;
  // Three-bit urgency, zero most urgent
  typedef logic [2:0] pic_level_t;
  // Source number 0 to 19
  typedef logic [4:0] pic_src_t;
  // Trigger codes in field order: 00 high, 01 low, 10 rise, 11 fall
  typedef enum logic [1:0] {
    PIC_TRIG_HIGH,
    PIC_TRIG_LOW,
    PIC_TRIG_RISE,
    PIC_TRIG_FALL
  } pic_trig_t;
endpackage : pic_pkg

// *** pkg/pic_trig_if.sv ***
`timescale 1ns/1ns
interface pic_trig_if;
  logic                pin_raw;   // Pin level, not yet synchronised
  pic_pkg::pic_trig_t  mode;      // Trigger selection
  logic                edge_clr;  // One-cycle clear of a latched edge
  logic                req;       // Request toward the priority logic
  logic                edge_evt;  // One-cycle pulse when an edge is caught
  modport core (output pin_raw, output mode, output edge_clr, input req, input edge_evt);
  modport trig (input pin_raw, input mode, input edge_clr, output req, output edge_evt);
endinterface : pic_trig_if

// *** core/pic_ext_trig.sv ***
`timescale 1ns/1ns
module pic_ext_trig (
  input wire logic core_clk,  // System clock
  input wire logic rst_n,     // Asynchronous reset, active low
  pic_trig_if.trig t          // Pin, mode and request
);
  logic sync1_reg;  // First synchroniser stage
  logic sync2_reg;  // Second stage, safe to use
  logic prev_reg;   // Previous safe sample
  logic latch_reg;  // Latched edge
  logic rise;
  logic fall;
  logic hit;

  // Two-stage synchroniser; stage one feeds stage two only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= t.pin_raw;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;
  assign hit  = (t.mode == pic_pkg::PIC_TRIG_RISE) ? rise :
                (t.mode == pic_pkg::PIC_TRIG_FALL) ? fall : 1'b0;

  // latch edge until cleared; a new edge beats the clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg <= 1'b0;
    end else if (hit) begin
      latch_reg <= 1'b1;
    end else if (t.edge_clr) begin
      latch_reg <= 1'b0;
    end
  end

  always_comb begin
    case (t.mode)
      pic_pkg::PIC_TRIG_HIGH: t.req = sync2_reg;
      pic_pkg::PIC_TRIG_LOW:  t.req = ~sync2_reg;
      default:                t.req = latch_reg;
    endcase
  end
  assign t.edge_evt = hit;

  property p_level_follows;
    @(posedge core_clk) disable iff (!rst_n)
      (t.mode == pic_pkg::PIC_TRIG_LOW) |-> (t.req == !sync2_reg);
  endproperty
  a_level_follows: assert property (p_level_follows) else $error("low level request wrong");

  sequence s_rise_seen;
    (t.mode == pic_pkg::PIC_TRIG_RISE) && !prev_reg && sync2_reg;
  endsequence
  property p_rise_latches;
    @(posedge core_clk) disable iff (!rst_n)
      s_rise_seen ##1 (t.mode == pic_pkg::PIC_TRIG_RISE) |-> t.req;
  endproperty
  a_rise_latches: assert property (p_rise_latches) else $error("rising edge not latched");

  property p_clear_drops;
    @(posedge core_clk) disable iff (!rst_n)
      (t.edge_clr && !hit) |=> !latch_reg;
  endproperty
  a_clear_drops: assert property (p_clear_drops) else $error("edge clear ignored");
endmodule : pic_ext_trig

// *** core/pic_ctrl.sv ***
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
`include "pic_defs.svh"
module pic_ctrl #(
  parameter int NSRC = 20  // Number of request sources
) (
  input  wire logic              core_clk,   // System clock
  input  wire logic              rst_n,      // Asynchronous reset, active low
  input  wire logic [31:0]       addr,       // Register byte address
  input  wire logic [31:0]       wr_data,    // Write data
  input  wire logic              wr_en,      // Write strobe
  input  wire logic              rd_en,      // Read strobe
  output logic      [31:0]       rd_data,    // Read data, cycle after strobe
  input  wire logic [NSRC-1:0]   src_req,    // Peripheral request levels
  input  wire logic [3:0]        ext_pin,    // External request pins
  output logic                   norm_irq,   // Normal request pending
  output logic                   fast_irq,   // Fast request pending
  output logic                   int_out     // Masked event interrupt
);
  localparam int NPIN = 4;

  logic [31:0]          prio_tim_reg;    // Timer priorities
  logic [31:0]          prio_per_reg;    // Peripheral priorities
  logic [31:0]          prio_slv_reg;    // Slave and pin priorities
  logic [31:0]          trig_cfg_reg;    // Pin trigger fields
  logic [7:0]           nest_stat_reg;   // Fast nesting status
  logic [15:0]          vec_base_reg;    // Vector base value
  logic [NSRC-1:0]      norm_en_reg;     // Normal source enable
  logic [NSRC-1:0]      fast_en_reg;     // Fast source enable
  logic [7:0]           nest_ctl_reg;    // Nesting control
  logic [2:0]           evt_stat_reg;    // Sticky events
  logic [2:0]           evt_mask_reg;    // Event mask
  logic [31:0]          rd_data_reg;     // Read data register
  logic                 norm_prev_reg;   // Last normal pending
  logic                 fast_prev_reg;   // Last fast pending

  pic_pkg::pic_level_t  lvl [NSRC];      // Level of each source
  logic [NSRC-1:0]      live_req;        // Requests with pins merged
  logic [NSRC-1:0]      allowed;         // Not blocked by nesting
  logic [NSRC-1:0]      norm_act;        // Active normal requests
  logic [NSRC-1:0]      fast_act;        // Active fast requests
  logic [3:0]           blk_lvl;         // Most urgent nesting level, 8 if none
  logic                 norm_found;
  pic_pkg::pic_src_t    norm_idx;
  pic_pkg::pic_level_t  norm_lvl;
  logic                 fast_found;
  pic_pkg::pic_src_t    fast_idx;
  pic_pkg::pic_level_t  fast_lvl;
  logic [NPIN-1:0]      pin_req;         // Pin requests from trigger logic
  logic [NPIN-1:0]      pin_evt;         // Pin edge pulses
  logic                 edge_clr_wr;     // Write to the edge clear register
  logic                 fast_vec_rd;     // Read of the fast vector
  logic [7:0]           nest_low;        // Most urgent set status bit
  logic [7:0]           nest_clr;
  logic [7:0]           nest_set;
  logic [2:0]           evt_set;
  logic [2:0]           evt_clr;

  // Pin trigger logic, one instance per pin
  pic_trig_if trig_if [NPIN] ();
  for (genvar g = 0; g < NPIN; g++) begin : g_pin
    assign trig_if[g].pin_raw  = ext_pin[g];
    // field 2g+1:2g selects pin g trigger
    assign trig_if[g].mode     = pic_pkg::pic_trig_t'(trig_cfg_reg[2*g +: 2]);
    assign trig_if[g].edge_clr = edge_clr_wr & wr_data[g];
    assign pin_req[g]          = trig_if[g].req;
    assign pin_evt[g]          = trig_if[g].edge_evt;
    pic_ext_trig pic_ext_trig_inst (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .t        (trig_if[g])
    );
  end

  // Pin slots take the trigger outputs; other slots pass the peripheral level
  always_comb begin
    live_req                = src_req;
    live_req[`PIC_SRC_PIN0] = pin_req[0];
    live_req[`PIC_SRC_PIN1] = pin_req[1];
    live_req[`PIC_SRC_PIN2] = pin_req[2];
    live_req[`PIC_SRC_PIN3] = pin_req[3];
  end

  // Gather levels; sources without a field sit at the most urgent level
  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      lvl[i] = 3'h0;
    end
    lvl[`PIC_SRC_SW]     = prio_tim_reg[`PIC_FLD_SW +: 3];
    lvl[`PIC_SRC_TIMER0] = prio_tim_reg[`PIC_FLD_TIMER0 +: 3];
    lvl[`PIC_SRC_TIMER1] = prio_tim_reg[`PIC_FLD_TIMER1 +: 3];
    lvl[`PIC_SRC_TIMER2] = prio_tim_reg[`PIC_FLD_TIMER2 +: 3];
    lvl[`PIC_SRC_TIMER3] = prio_tim_reg[`PIC_FLD_TIMER3 +: 3];
    lvl[`PIC_SRC_CONV]   = prio_per_reg[`PIC_FLD_CONV +: 3];
    lvl[`PIC_SRC_ASYNC]  = prio_per_reg[`PIC_FLD_ASYNC +: 3];
    lvl[`PIC_SRC_SPI_M]  = prio_per_reg[`PIC_FLD_SPI_M +: 3];
    lvl[`PIC_SRC_PIN0]   = prio_per_reg[`PIC_FLD_PIN0 +: 3];
    lvl[`PIC_SRC_PIN1]   = prio_per_reg[`PIC_FLD_PIN1 +: 3];
    lvl[`PIC_SRC_TWI_M]  = prio_per_reg[`PIC_FLD_TWI_M +: 3];
    lvl[`PIC_SRC_TWI_S]  = prio_slv_reg[`PIC_FLD_TWI_S +: 3];
    lvl[`PIC_SRC_SPI_S]  = prio_slv_reg[`PIC_FLD_SPI_S +: 3];
    lvl[`PIC_SRC_PIN2]   = prio_slv_reg[`PIC_FLD_PIN2 +: 3];
    lvl[`PIC_SRC_PIN3]   = prio_slv_reg[`PIC_FLD_PIN3 +: 3];
  end

  // lowest set status bit is the blocking threshold
  always_comb begin
    blk_lvl = `PIC_NO_BLOCK;
    for (int k = 7; k >= 0; k--) begin
      if (nest_stat_reg[k]) begin
        blk_lvl = 4'(k);
      end
    end
  end

  // block equal and less urgent levels
  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      allowed[i] = ({1'b0, lvl[i]} < blk_lvl);
    end
  end
  assign norm_act = live_req & norm_en_reg & allowed;
  assign fast_act = live_req & fast_en_reg & allowed;

  // most urgent level wins, lowest number on a tie
  always_comb begin
    norm_found = 1'b0;
    norm_idx   = 5'h0;
    norm_lvl   = 3'h7;
    fast_found = 1'b0;
    fast_idx   = 5'h0;
    fast_lvl   = 3'h7;
    for (int i = 0; i < NSRC; i++) begin
      if (norm_act[i] && (!norm_found || lvl[i] < norm_lvl)) begin
        norm_found = 1'b1;
        norm_idx   = 5'(i);
        norm_lvl   = lvl[i];
      end
      if (fast_act[i] && (!fast_found || lvl[i] < fast_lvl)) begin
        fast_found = 1'b1;
        fast_idx   = 5'(i);
        fast_lvl   = lvl[i];
      end
    end
  end

  // Plain configuration registers; reserved bits stay zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prio_tim_reg <= `PIC_RST_WORD;
      prio_per_reg <= `PIC_RST_WORD;
      prio_slv_reg <= `PIC_RST_WORD;
      trig_cfg_reg <= `PIC_RST_WORD;
      vec_base_reg <= 16'h0000;
      norm_en_reg  <= '0;
      fast_en_reg  <= '0;
      nest_ctl_reg <= `PIC_RST_BYTE;
      evt_mask_reg <= 3'h0;
    end else if (wr_en) begin
      case (addr)
        `PIC_OFF_PRIO_TIMERS: prio_tim_reg <= wr_data & `PIC_MASK_PRIO_TIMERS;
        `PIC_OFF_PRIO_PERIPH: prio_per_reg <= wr_data & `PIC_MASK_PRIO_PERIPH;
        `PIC_OFF_PRIO_SLAVES: prio_slv_reg <= wr_data & `PIC_MASK_PRIO_SLAVES;
        `PIC_OFF_TRIG_CFG:    trig_cfg_reg <= wr_data & `PIC_MASK_TRIG_CFG;
        `PIC_OFF_VEC_BASE:    vec_base_reg <= wr_data[15:0];
        `PIC_OFF_NORM_EN:     norm_en_reg  <= wr_data[NSRC-1:0];
        `PIC_OFF_FAST_EN:     fast_en_reg  <= wr_data[NSRC-1:0];
        `PIC_OFF_NEST_CTL:    nest_ctl_reg <= wr_data[7:0];
        `PIC_OFF_EVT_MASK:    evt_mask_reg <= wr_data[2:0];
        default:              nest_ctl_reg <= nest_ctl_reg;
      endcase
    end
  end

  assign edge_clr_wr = wr_en && (addr == `PIC_OFF_EDGE_CLR);
  assign fast_vec_rd = rd_en && (addr == `PIC_OFF_FAST_VEC);

  // isolate the most urgent set bit, whatever was written
  assign nest_low = nest_stat_reg & (~nest_stat_reg + 8'h01);
  assign nest_clr = (wr_en && addr == `PIC_OFF_NEST_STAT) ? nest_low : 8'h00;
  // fast vector read with nesting on sets the level bit
  assign nest_set = (fast_vec_rd && nest_ctl_reg[`PIC_NEST_EN_BIT] && fast_found) ?
                    (8'h01 << fast_lvl) : 8'h00;

  // Nesting status; a set in the clearing cycle survives
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nest_stat_reg <= `PIC_RST_BYTE;
    end else begin
      nest_stat_reg <= (nest_stat_reg & ~nest_clr) | nest_set;
    end
  end

  // Events: normal pending rose, fast pending rose, any pin edge
  assign evt_set = {|pin_evt, fast_found & ~fast_prev_reg, norm_found & ~norm_prev_reg};
  assign evt_clr = (wr_en && addr == `PIC_OFF_EVT_STAT) ? wr_data[2:0] : 3'h0;

  // Sticky events, write one to clear, set wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_stat_reg  <= 3'h0;
      norm_prev_reg <= 1'b0;
      fast_prev_reg <= 1'b0;
    end else begin
      evt_stat_reg  <= (evt_stat_reg & ~evt_clr) | evt_set;
      norm_prev_reg <= norm_found;
      fast_prev_reg <= fast_found;
    end
  end

  // Read data registered; unmapped addresses answer zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg <= `PIC_RST_WORD;
    end else if (rd_en) begin
      case (addr)
        `PIC_OFF_PRIO_TIMERS: rd_data_reg <= prio_tim_reg;
        `PIC_OFF_PRIO_PERIPH: rd_data_reg <= prio_per_reg;
        `PIC_OFF_PRIO_SLAVES: rd_data_reg <= prio_slv_reg;
        `PIC_OFF_TRIG_CFG:    rd_data_reg <= trig_cfg_reg;
        `PIC_OFF_NEST_STAT:   rd_data_reg <= {24'h00_0000, nest_stat_reg};
        // zeros, base, source number, reserved zeros
        `PIC_OFF_NORM_VEC:    rd_data_reg <= {9'h000, vec_base_reg, norm_idx, 2'b00};
        `PIC_OFF_FAST_VEC:    rd_data_reg <= {9'h000, vec_base_reg, fast_idx, 2'b00};
        `PIC_OFF_VEC_BASE:    rd_data_reg <= {16'h0000, vec_base_reg};
        `PIC_OFF_NORM_EN:     rd_data_reg <= 32'(norm_en_reg);
        `PIC_OFF_FAST_EN:     rd_data_reg <= 32'(fast_en_reg);
        `PIC_OFF_NEST_CTL:    rd_data_reg <= {24'h00_0000, nest_ctl_reg};
        `PIC_OFF_EVT_STAT:    rd_data_reg <= {29'h0000_0000, evt_stat_reg};
        `PIC_OFF_EVT_MASK:    rd_data_reg <= {29'h0000_0000, evt_mask_reg};
        `PIC_OFF_RAW_REQ:     rd_data_reg <= 32'(live_req);
        default:              rd_data_reg <= `PIC_RST_WORD;
      endcase
    end
  end

  assign rd_data  = rd_data_reg;
  assign norm_irq = norm_found;
  assign fast_irq = fast_found;
  assign int_out  = |(evt_stat_reg & evt_mask_reg);

  // Checks on the register bus and priority logic
  sequence s_rd_norm_vec;
    rd_en && (addr == `PIC_OFF_NORM_VEC);
  endsequence

  property p_vec_layout;
    @(posedge core_clk) disable iff (!rst_n)
      s_rd_norm_vec |=> (rd_data[31:23] == 9'h000) && (rd_data[1:0] == 2'b00) &&
                        (rd_data[22:7] == $past(vec_base_reg));
  endproperty
  a_vec_layout: assert property (p_vec_layout) else $error("vector layout wrong");

  property p_vec_timer1;
    @(posedge core_clk) disable iff (!rst_n)
      s_rd_norm_vec ##0 (norm_act == 20'h0_0100) |=> (rd_data[6:2] == 5'b01000);
  endproperty
  a_vec_timer1: assert property (p_vec_timer1) else $error("timer one number wrong");

  property p_urgent_wins;
    @(posedge core_clk) disable iff (!rst_n)
      norm_act[`PIC_SRC_TIMER1] |-> norm_found && (norm_lvl <= lvl[`PIC_SRC_TIMER1]);
  endproperty
  a_urgent_wins: assert property (p_urgent_wins) else $error("less urgent source chosen");

  sequence s_wr_at(logic [31:0] a);
    wr_en && (addr == a);
  endsequence
  sequence s_rd_at(logic [31:0] a);
    rd_en && (addr == a);
  endsequence

  property p_prio_tim;
    @(posedge core_clk) disable iff (!rst_n)
      s_wr_at(`PIC_OFF_PRIO_TIMERS) ##1 s_rd_at(`PIC_OFF_PRIO_TIMERS) |=>
        rd_data == ($past(wr_data, 2) & `PIC_MASK_PRIO_TIMERS);
  endproperty
  a_prio_tim: assert property (p_prio_tim) else $error("timer priorities read back wrong");

  property p_prio_per;
    @(posedge core_clk) disable iff (!rst_n)
      s_wr_at(`PIC_OFF_PRIO_PERIPH) |=> lvl[`PIC_SRC_TWI_M] == $past(wr_data[30:28]);
  endproperty
  a_prio_per: assert property (p_prio_per) else $error("two-wire master level wrong");

  property p_prio_slv;
    @(posedge core_clk) disable iff (!rst_n)
      s_wr_at(`PIC_OFF_PRIO_SLAVES) |=> lvl[`PIC_SRC_TWI_S] == $past(wr_data[2:0]) &&
                                         prio_slv_reg[31:15] == 17'h0_0000;
  endproperty
  a_prio_slv: assert property (p_prio_slv) else $error("slave priorities wrong");

  property p_nest_set;
    @(posedge core_clk) disable iff (!rst_n)
      fast_vec_rd && nest_ctl_reg[`PIC_NEST_EN_BIT] && fast_found |=>
        nest_stat_reg[$past(fast_lvl)];
  endproperty
  a_nest_set: assert property (p_nest_set) else $error("nesting bit not set");

  property p_block;
    @(posedge core_clk) disable iff (!rst_n)
      (blk_lvl <= {1'b0, lvl[`PIC_SRC_TIMER1]}) |->
        !norm_act[`PIC_SRC_TIMER1] && !fast_act[`PIC_SRC_TIMER1];
  endproperty
  a_block: assert property (p_block) else $error("blocked level passed");

  property p_one_clear;
    @(posedge core_clk) disable iff (!rst_n)
      s_wr_at(`PIC_OFF_NEST_STAT) ##0 !fast_vec_rd |=>
        nest_stat_reg == ($past(nest_stat_reg) & ~$past(nest_low));
  endproperty
  a_one_clear: assert property (p_one_clear) else $error("status clear wrong");
endmodule : pic_ctrl

// *** tb/pic_src_model.sv ***
`timescale 1ns/1ns
// Far side: peripheral request lines and the four external pins
module pic_src_model (
  input  wire logic        core_clk,  // System clock
  input  wire logic        rst_n,     // Asynchronous reset, active low
  input  wire logic [19:0] req_cmd,   // Wanted request levels
  input  wire logic [3:0]  pin_cmd,   // Wanted pin levels
  output logic      [19:0] src_req,   // Request lines toward the block
  output logic      [3:0]  ext_pin    // Pin levels toward the block
);
  // Sources change just after an edge, one cycle behind the command,
  // so the block never sees a pin move in the same step as its clock
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_req <= 20'h0_0000;
      ext_pin <= 4'h0;
    end else begin
      src_req <= req_cmd;
      ext_pin <= pin_cmd;
    end
  end
endmodule : pic_src_model

// *** tb/tb_prioritised_interrupt_controller.sv ***
`timescale 1ns/1ns
`include "pic_defs.svh"
module tb_prioritised_interrupt_controller;
  logic        core_clk;  // System clock
  logic        rst_n;     // Reset, active low
  logic [31:0] addr;      // Bus address
  logic [31:0] wr_data;   // Bus write data
  logic        wr_en;     // Write strobe
  logic        rd_en;     // Read strobe
  logic [31:0] rd_data;   // Bus read data
  logic [19:0] src_req;   // Model request lines
  logic [3:0]  ext_pin;   // Model pins
  logic [19:0] req_cmd;   // Requests asked of the model
  logic [3:0]  pin_cmd;   // Pin levels asked of the model
  logic        norm_irq;  // Normal request out
  logic        fast_irq;  // Fast request out
  logic        int_out;   // Event interrupt out
  logic [31:0] d;         // Last read word
  int          fails;     // Mismatch count
  int          tests_run; // Comparison count
  int          pin_src[4] = '{12, 13, 15, 16};  // Source numbers of pins 0 to 3

  pic_ctrl #(.NSRC(20)) pic_ctrl_inst (.core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .src_req(src_req), .ext_pin(ext_pin),
    .norm_irq(norm_irq), .fast_irq(fast_irq), .int_out(int_out));
  pic_src_model pic_src_model_inst (.core_clk(core_clk), .rst_n(rst_n), .req_cmd(req_cmd),
    .pin_cmd(pin_cmd), .src_req(src_req), .ext_pin(ext_pin));

  // Free-running 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Edge wait, then step off the edge so outputs have settled
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wt

  // One-cycle write strobe
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge core_clk);
    wr_en <= 1'b1; addr <= a; wr_data <= v;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask : wr

  // One-cycle read strobe; data stands from the following cycle until the next read
  task automatic rd(input logic [31:0] a);
    @(posedge core_clk);
    rd_en <= 1'b1; addr <= a;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask : rd

  // Write strobe followed at once by a read strobe of the same place
  task automatic wrrd(input logic [31:0] a, input logic [31:0] v);
    @(posedge core_clk);
    wr_en <= 1'b1; addr <= a; wr_data <= v;
    @(posedge core_clk);
    wr_en <= 1'b0; rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask : wrrd

  // Word compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Flag compare
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  // Register reset values, full masks and an unmapped place
  task automatic t_regs();
    rd(`PIC_OFF_PRIO_TIMERS); chk(d, 32'h0000_0000);  // reset
    rd(`PIC_OFF_TRIG_CFG);    chk(d, 32'h0000_0000);  // reset
    rd(`PIC_OFF_NEST_STAT);   chk(d, 32'h0000_0000);  // reset
    wr(`PIC_OFF_PRIO_PERIPH, 32'hFFFF_FFFF);
    wr(`PIC_OFF_PRIO_SLAVES, 32'hFFFF_FFFF);
    wr(32'hFFFF_0300, 32'hFFFF_FFFF);
    wrrd(`PIC_OFF_PRIO_TIMERS, 32'hFFFF_FFFF); chk(d, 32'h0777_7070);  // field layout
    rd(`PIC_OFF_PRIO_PERIPH); chk(d, 32'h7777_7700);  // field layout
    rd(`PIC_OFF_PRIO_SLAVES); chk(d, 32'h0000_7777);  // field layout
    rd(32'hFFFF_0300);        chk(d, 32'h0000_0000);  // unmapped reads zero
  endtask : t_regs

  // Timer1 at level 2 beats timer0 at level 3 despite its higher number
  task automatic t_vector();
    req_cmd <= 20'h0_0180;
    wr(`PIC_OFF_PRIO_TIMERS, 32'h0002_3000);
    wr(`PIC_OFF_VEC_BASE, 32'h0000_ABCD);
    wr(`PIC_OFF_NORM_EN, 32'h0000_0180);
    wt(2);
    chk1(norm_irq, 1'b1);                         // request reaches output
    rd(`PIC_OFF_NORM_VEC); chk(d, 32'h0055_E6A0); // base and source 01000
    rd(`PIC_OFF_RAW_REQ);  chk(d, 32'h0000_0180); // requests by source number
  endtask : t_vector

  // Two nested fast entries, then unwinding one bit per write
  task automatic t_nesting();
    wr(`PIC_OFF_FAST_EN, 32'h0000_0100);
    wr(`PIC_OFF_NEST_CTL, 32'h0000_0002);
    rd(`PIC_OFF_FAST_VEC); chk(d, 32'h0055_E6A0);  // fast vector layout
    rd(`PIC_OFF_NEST_STAT); chk(d, 32'h0000_0004); // level two sets bit two
    chk1(norm_irq, 1'b0);                          // levels two and three blocked
    wr(`PIC_OFF_PRIO_TIMERS, 32'h0000_3000);
    wt(1);
    chk1(fast_irq, 1'b1);                          // more urgent passes
    rd(`PIC_OFF_FAST_VEC); chk(d, 32'h0055_E6A0);  // timer one still wins
    rd(`PIC_OFF_NEST_STAT); chk(d, 32'h0000_0005); // level zero sets bit zero
    chk1(fast_irq, 1'b0);                          // bit zero blocks all
    wr(`PIC_OFF_NEST_STAT, 32'h0000_00FF);
    rd(`PIC_OFF_NEST_STAT); chk(d, 32'h0000_0004); // most urgent cleared
    wr(`PIC_OFF_NEST_STAT, 32'h0000_00FF);
    rd(`PIC_OFF_NEST_STAT); chk(d, 32'h0000_0000); // second clear
    chk1(norm_irq, 1'b1);                          // block released
    wr(`PIC_OFF_FAST_EN, 32'h0000_0000);
    req_cmd <= 20'h0_0100;
    wt(2);
    rd(`PIC_OFF_NORM_VEC); chk(d, 32'h0055_E6A0);  // timer one alone reads 01000
    req_cmd <= 20'h0_0000;
  endtask : t_nesting

  // Pin g uses trigger code g: high, low, rising, falling
  task automatic t_pins();
    wr(`PIC_OFF_TRIG_CFG, 32'h0000_00E4);
    pin_cmd <= 4'hA;
    wt(6);
    wr(`PIC_OFF_EDGE_CLR, 32'h0000_000F);
    for (int g = 0; g < 4; g++) begin
      wr(`PIC_OFF_NORM_EN, 32'h0000_0001 << pin_src[g]);
      pin_cmd[g] <= ~pin_cmd[g];
      wt(6);
      chk1(norm_irq, 1'b1);               // selected level or edge fires
      pin_cmd[g] <= ~pin_cmd[g];
      wt(6);
      chk1(norm_irq, g >= 2);             // edge held, level follows pin
      wr(`PIC_OFF_EDGE_CLR, 32'h0000_0001 << g);
      wt(2);
      chk1(norm_irq, 1'b0);               // latch cleared
    end
  endtask : t_pins

  // Sticky events, mask and write-one clear
  task automatic t_events();
    wr(`PIC_OFF_EVT_MASK, 32'h0000_0000);
    wt(1);
    chk1(int_out, 1'b0);                        // masked event quiet
    wr(`PIC_OFF_EVT_MASK, 32'h0000_0004);
    wt(1);
    chk1(int_out, 1'b1);                        // pin edge event raised
    wr(`PIC_OFF_EVT_STAT, 32'h0000_0007);
    wt(1);
    chk1(int_out, 1'b0);                        // cleared by write of ones
    rd(`PIC_OFF_EVT_STAT); chk(d, 32'h0000_0000); // status empty
  endtask : t_events

  // Counts, verdict and end of run
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    fails = 0; tests_run = 0;
    rst_n = 1'b0; addr = 32'h0000_0000; wr_data = 32'h0000_0000;
    wr_en = 1'b0; rd_en = 1'b0; req_cmd = 20'h0_0000; pin_cmd = 4'h0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_vector();
    t_nesting();
    t_pins();
    t_events();
    finish_test();
  end

  // Watchdog: the run needs well under a thousand cycles
  initial begin
    #100000;
    fails++;
    finish_test();
  end
endmodule : tb_prioritised_interrupt_controller
